// >>> rtl/rsi_reset_state_init.sv
// reset-state initializer: loads the reset column of the core, clock, port,
// reset-control, watchdog and interrupt registers for each reset cause
// assumes cause_valid/cause_code come from reset generators on pclk
//
// Summary of operation
// - power-on clears the time-out and power-down flags in status
// - pin or low-voltage reset in run mode keeps both flags
// - run-mode watchdog reset sets time-out, keeps power-down
// - idle or sleep watchdog reset sets both flags
// - power-on disables every interrupt source
// - any reset clears watchdog and time base counters; watchdog counts at once
// - power-on switches all timer modules off
// - after reset the stack pointer addresses the top of stack
// - port A data/direction go all ones, pull-up/wake-up zero; idle watchdog keeps
// - indirect address and memory pointer clear, kept on idle watchdog reset
// - accumulator and table registers undefined at power-on, kept otherwise
// - program counter low byte clears on every cause
// - status upper bits: undefined at power-on, kept on pin, low-voltage and both watchdog resets
// - reset flags clear at power-on; low-voltage sets its flag; others keep
// - reset-pin function control loads 0x55 except on idle watchdog reset
// - threshold select loads 0x55, kept on low-voltage and idle watchdog resets
// - idle watchdog reset clears pc and stack pointer, sets both status flags; all other entry bits keep their state
`default_nettype none
module rsi_reset_state_init
   import rsi_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rsi_pkg::RSI_AW-1:0] paddr,
   input wire logic [rsi_pkg::RSI_DW-1:0] pwdata,
   output logic [rsi_pkg::RSI_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cause_valid,
   input wire rsi_pkg::rsi_cause_t cause_code,
   output logic cpu_run,
   output logic [7:0] port_a_data,
   output logic [7:0] port_a_direction,
   output logic [7:0] port_a_pullup,
   output logic [7:0] port_a_wakeup,
   output logic [rsi_pkg::INT_CTL_IMPL_W-1:0] int_enable,
   output logic [7:0] timers_on
);
   import rsi_pkg::*;

   logic [7:0] regs_q [RSI_NREG];
   logic [7:0] apply_val [RSI_NREG];
   logic [RSI_NREG-1:0] keep_vec;
   logic [RSI_WDT_W-1:0] wdt_cnt;
   logic [RSI_TB_W-1:0] tb_cnt;
   logic [RSI_DW-1:0] prdata_q;
   logic [RSI_DW-1:0] rd_val;
   logic pready_q;
   logic pslverr_q;
   logic cpu_run_q;
   logic release_q;
   logic [2:0] last_cause_q;
   logic [RSI_IW-1:0] idx;
   logic addr_ok;
   logic wr_take;
   logic is_wdt;
   logic is_idle;
   logic is_lv;

   assign idx = paddr[RSI_IW+1:2];
   assign addr_ok = (paddr[1:0] == 2'b00) && (idx < RSI_IW'(RSI_NIDX))
      && (paddr[RSI_AW-1] == 1'b0);
   assign wr_take = psel && penable && pready_q && pwrite && addr_ok;

   assign is_wdt = (cause_code == CAUSE_WDT_RUN) || (cause_code == CAUSE_WDT_IDLE);
   assign is_idle = (cause_code == CAUSE_WDT_IDLE);
   assign is_lv = (cause_code == CAUSE_LOW_VOLTAGE);

   // an illegal cause code is treated as power-on, the safest column
   always_comb begin
      unique case (cause_code)
         CAUSE_POWER_ON: keep_vec = KEEP_NONE;
         CAUSE_PIN: keep_vec = KEEP_PIN;
         CAUSE_LOW_VOLTAGE: keep_vec = KEEP_LOW_VOLTAGE;
         CAUSE_WDT_RUN: keep_vec = KEEP_WDT_RUN;
         CAUSE_WDT_IDLE: keep_vec = KEEP_WDT_IDLE;
         default: keep_vec = KEEP_NONE;
      endcase
   end

   // column selection; undefined contents are loaded as the power-on value
   always_comb begin
      for (int i = 0; i < RSI_NREG; i++) begin
         apply_val[i] = keep_vec[i] ? regs_q[i] : RSI_RST_VAL[i];
      end
      if (is_wdt) begin
         apply_val[IDX_STATUS][ST_TIMEOUT] = 1'b1;
      end
      if (is_idle) begin
         apply_val[IDX_STATUS][ST_POWERDOWN] = 1'b1;
      end
      if (is_lv) begin
         apply_val[IDX_RSTFLAG][RF_LVRF] = 1'b1;
      end
   end

   // one flip-flop byte per entry; a cause event overrides a same-cycle write
   // so a hardware-set flag is never lost to a software clear
   // stack pointer read-only
   for (genvar g = 0; g < RSI_NREG; g++) begin : g_reg
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            regs_q[g] <= RSI_RST_VAL[g];
         end else if (cause_valid) begin
            regs_q[g] <= apply_val[g];
         end else if (wr_take && (idx == RSI_IW'(g))) begin
            regs_q[g] <= (regs_q[g] & ~RSI_WR_MASK[g]) | (pwdata[7:0] & RSI_WR_MASK[g]);
         end
      end
   end

   rsi_free_counter #(
      .W(RSI_WDT_W)
   ) u_wdt_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .clr(cause_valid),
      .count_q(wdt_cnt)
   );

   rsi_free_counter #(
      .W(RSI_TB_W)
   ) u_tb_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .clr(cause_valid),
      .count_q(tb_cnt)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_run_q <= 1'b0;
         release_q <= 1'b0;
      end else if (cause_valid) begin
         cpu_run_q <= 1'b0;
         release_q <= 1'b1;
      end else if (release_q) begin
         cpu_run_q <= 1'b1;
         release_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_cause_q <= 3'h0;
      end else if (cause_valid) begin
         last_cause_q <= cause_code;
      end
   end

   // read view; reserved bits and unused upper bits read as zero
   always_comb begin
      rd_val = '0;
      if (idx < RSI_IW'(RSI_NREG)) begin
         rd_val[7:0] = regs_q[idx];
      end else if (idx == IDX_WDT_CNT) begin
         rd_val[RSI_WDT_W-1:0] = wdt_cnt;
      end else if (idx == IDX_TB_CNT) begin
         rd_val[RSI_TB_W-1:0] = tb_cnt;
      end else if (idx == IDX_CAUSE) begin
         rd_val[3:0] = {cpu_run_q, last_cause_q};
      end
   end

   // one wait state: data captured in setup, pready in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !addr_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (psel && !penable) begin
         prdata_q <= (addr_ok && !pwrite) ? rd_val : '0;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign cpu_run = cpu_run_q;
   assign port_a_data = regs_q[IDX_PORT_A_DATA];
   assign port_a_direction = regs_q[IDX_PORT_A_DIR];
   assign port_a_pullup = regs_q[IDX_PORT_A_PU];
   assign port_a_wakeup = regs_q[IDX_PORT_A_WU];
   assign int_enable = regs_q[IDX_INT_CTL_0][INT_CTL_IMPL_W-1:0];
   assign timers_on = regs_q[IDX_TMR];
endmodule
`default_nettype wire

// >>> shared/rsi_pkg.sv
// constants, register map and reset columns of the reset-state initializer
// assumes one clock domain; reset-cause events arrive from same-clock logic
`default_nettype none
package rsi_pkg;
   // reset causes as delivered by the reset generators
   typedef enum logic [2:0] {
      CAUSE_POWER_ON,
      CAUSE_PIN,
      CAUSE_LOW_VOLTAGE,
      CAUSE_WDT_RUN,
      CAUSE_WDT_IDLE
   } rsi_cause_t;

   localparam int RSI_AW = 8;
   localparam int RSI_DW = 32;
   localparam int RSI_IW = 5;
   localparam int RSI_NREG = 20;
   localparam int RSI_NIDX = 23;
   localparam int RSI_WDT_W = 16;
   localparam int RSI_TB_W = 16;

   // register indices, byte address is four times the index
   localparam logic [RSI_IW-1:0] IDX_STATUS = 5'h00;
   localparam logic [RSI_IW-1:0] IDX_PC_LOW = 5'h01;
   localparam logic [RSI_IW-1:0] IDX_ACC = 5'h02;
   localparam logic [RSI_IW-1:0] IDX_TABLE_PTR = 5'h03;
   localparam logic [RSI_IW-1:0] IDX_TABLE_HIGH = 5'h04;
   localparam logic [RSI_IW-1:0] IDX_INDIRECT_0 = 5'h05;
   localparam logic [RSI_IW-1:0] IDX_MEM_PTR_0 = 5'h06;
   localparam logic [RSI_IW-1:0] IDX_RSTFLAG = 5'h07;
   localparam logic [RSI_IW-1:0] IDX_CLK_CTL = 5'h08;
   localparam logic [RSI_IW-1:0] IDX_FOSC = 5'h09;
   localparam logic [RSI_IW-1:0] IDX_PORT_A_DATA = 5'h0a;
   localparam logic [RSI_IW-1:0] IDX_PORT_A_DIR = 5'h0b;
   localparam logic [RSI_IW-1:0] IDX_PORT_A_PU = 5'h0c;
   localparam logic [RSI_IW-1:0] IDX_PORT_A_WU = 5'h0d;
   localparam logic [RSI_IW-1:0] IDX_RSTPIN = 5'h0e;
   localparam logic [RSI_IW-1:0] IDX_LVSEL = 5'h0f;
   localparam logic [RSI_IW-1:0] IDX_WDT_CTL = 5'h10;
   localparam logic [RSI_IW-1:0] IDX_INT_CTL_0 = 5'h11;
   localparam logic [RSI_IW-1:0] IDX_TMR = 5'h12;
   localparam logic [RSI_IW-1:0] IDX_SP = 5'h13;
   localparam logic [RSI_IW-1:0] IDX_WDT_CNT = 5'h14;
   localparam logic [RSI_IW-1:0] IDX_TB_CNT = 5'h15;
   localparam logic [RSI_IW-1:0] IDX_CAUSE = 5'h16;

   // bit positions
   localparam int ST_TIMEOUT = 5;
   localparam int ST_POWERDOWN = 4;
   localparam int RF_LVRF = 2;
   localparam int INT_CTL_IMPL_W = 7;

   // power-on column, entry order follows the indices above
   localparam logic [7:0] RSI_RST_VAL [RSI_NREG] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
      8'hff, 8'hff, 8'h00, 8'h00, 8'h55, 8'h55, 8'h53, 8'h00, 8'h00, 8'h00};
   // implemented, software-writable bits
   localparam logic [7:0] RSI_WR_MASK [RSI_NREG] = '{
      8'hcf, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hef, 8'h0f,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'h00};

   // one bit per entry: 1 keeps the contents through that cause
   localparam logic [RSI_NREG-1:0] KEEP_PIN = 20'h0_009d;
   localparam logic [RSI_NREG-1:0] KEEP_LOW_VOLTAGE = 20'h0_809d;
   localparam logic [RSI_NREG-1:0] KEEP_WDT_RUN = 20'h0_009d;
   localparam logic [RSI_NREG-1:0] KEEP_WDT_IDLE = 20'h7_fffd;
   localparam logic [RSI_NREG-1:0] KEEP_NONE = 20'h0_0000;
endpackage
`default_nettype wire

// >>> rtl/rsi_free_counter.sv
// free-running up counter, cleared synchronously by a pulse
// assumes clr comes from logic on the same clock
`default_nettype none
module rsi_free_counter #(
   parameter int W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   output logic [W-1:0] count_q
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= '0;
      end else if (clr) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> tb/rsi_reset_state_init_asserts.sv
// port checker of the reset-state initializer
// assumes one clock, pclk, and the async low reset presetn
`default_nettype none
module rsi_chk
   import rsi_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [rsi_pkg::RSI_AW-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cause_valid,
   input wire rsi_pkg::rsi_cause_t cause_code,
   input wire logic cpu_run,
   input wire logic [7:0] port_a_data,
   input wire logic [7:0] port_a_direction,
   input wire logic [7:0] port_a_pullup,
   input wire logic [7:0] port_a_wakeup,
   input wire logic [rsi_pkg::INT_CTL_IMPL_W-1:0] int_enable,
   input wire logic [7:0] timers_on
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic cv_full;
   logic cv_idle;
   assign cv_full = cause_valid && cause_code != CAUSE_WDT_IDLE;
   assign cv_idle = cause_valid && cause_code == CAUSE_WDT_IDLE;
   sequence s_setup; psel && !penable; endsequence
   sequence s_answer; !pready ##1 pready; endsequence
   sequence s_pulse; cause_valid ##1 !cause_valid; endsequence
   property p_ans; s_setup |=> s_answer; endproperty
   property p_one; pready |=> !pready; endproperty
   property p_err; pready && paddr[1:0] != 2'b00 |-> pslverr; endproperty
   property p_port; cv_full |=> port_a_data == 8'hff && port_a_direction == 8'hff
      && port_a_pullup == 8'h00 && port_a_wakeup == 8'h00; endproperty
   property p_keep; cv_idle |=> $stable(port_a_data) && $stable(port_a_direction)
      && $stable(port_a_pullup) && $stable(port_a_wakeup); endproperty
   property p_int; cv_full |=> int_enable == '0; endproperty
   property p_tmr; cv_full |=> timers_on == 8'h00; endproperty
   // release is deferred while pulses follow each other
   property p_run; s_pulse |-> !cpu_run ##1 cpu_run; endproperty
   a_ans: assert property (p_ans) else $error("apb answer not after one wait");
   a_one: assert property (p_one) else $error("pready longer than one cycle");
   a_err: assert property (p_err) else $error("misaligned access not refused");
   a_port: assert property (p_port) else $error("port a not loaded");
   a_keep: assert property (p_keep) else $error("port a changed");
   a_int: assert property (p_int) else $error("interrupts left on");
   a_tmr: assert property (p_tmr) else $error("timers left on");
   a_run: assert property (p_run) else $error("cpu release timing");
endmodule
bind rsi_reset_state_init rsi_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr,
   .pready, .pslverr, .cause_valid, .cause_code, .cpu_run, .port_a_data,
   .port_a_direction, .port_a_pullup, .port_a_wakeup, .int_enable, .timers_on);
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench: random writes, every reset cause, full register readback
// assumes apb answers after one wait state and causes arrive as one-cycle pulses
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rsi_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cause_valid = 0;
   logic [7:0] paddr = 0, d;
   logic [31:0] pwdata = 0, prdata, r, r2;
   logic pready, pslverr, cpu_run, e;
   rsi_cause_t cause_code = CAUSE_POWER_ON;
   logic [7:0] port_a_data, port_a_direction, port_a_pullup, port_a_wakeup, timers_on;
   logic [INT_CTL_IMPL_W-1:0] int_enable;
   logic [7:0] mdl [20] = RSI_RST_VAL;
   int n_mismatch = 0, tests_run = 0, seed = 32'hcdb7c7e6, k, i, c;
   rsi_reset_state_init dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .cause_valid, .cause_code, .cpu_run, .port_a_data,
      .port_a_direction, .port_a_pullup, .port_a_wakeup, .int_enable, .timers_on);
   always #20 pclk = ~pclk;
   // expected register after cause cc, from its old value o
   function automatic logic [7:0] nxt(int j, int cc, logic [7:0] o);
      if (cc == 4) return (j == 1 || j == 19) ? 8'h00 : (j == 0 ? o | 8'h30 : o);
      case (j)
         0: return cc == 0 ? 8'h00 : (cc == 3 ? o | 8'h20 : o);
         2, 3, 4: return cc == 0 ? 8'h00 : o;
         7: return cc == 0 ? 8'h00 : (cc == 2 ? o | 8'h04 : o);
         9: return 8'h01;
         10, 11: return 8'hff;
         14: return 8'h55;
         15: return cc == 2 ? o : 8'h55;
         16: return 8'h53;
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // psel stays up between transfers so back-to-back setups need no gap
   task automatic apb(input logic w, input int a, input logic [7:0] dd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a[7:0];
      pwdata <= {24'h0, dd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_mismatch++;
      r = prdata;
      e = pslverr;
      penable <= 1'b0;
   endtask
   task automatic pulse(input int cc);
      psel <= 1'b0;
      cause_valid <= 1'b1;
      cause_code <= rsi_cause_t'(cc);
      @(posedge pclk);
      cause_valid <= 1'b0;
      // codes above the last cause load the power-on column
      for (int j = 0; j < 20; j++) mdl[j] = nxt(j, cc > 4 ? 0 : cc, mdl[j]);
      @(posedge pclk);
   endtask
   task automatic check_all();
      for (int j = 0; j < 20; j++) begin
         apb(1'b0, 4 * j, 8'h00);
         if (j < 8) chk(r, {24'h0, mdl[j]});
         else chk(r, {24'h0, mdl[j]});
      end
      chk({port_a_data, port_a_direction, port_a_pullup, port_a_wakeup},
         {mdl[10], mdl[11], mdl[12], mdl[13]});
      chk({17'h0, int_enable, timers_on}, {17'h0, mdl[17][6:0], mdl[18]});
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // about 16 rounds of roughly 100 cycles; far above that means a hang
   initial begin
      #800000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (k = 0; k < 16; k++) begin
         repeat (6) begin
            i = {$random(seed)} % 20;
            d = 8'($random(seed));
            apb(1'b1, 4 * i, d);
            mdl[i] = (mdl[i] & ~RSI_WR_MASK[i]) | (d & RSI_WR_MASK[i]);
         end
         apb(1'b1, 4 * IDX_SP, 8'hff);
         // corner: unused code 7 must act as power-on
         c = k < 5 ? k : (k == 5 ? 7 : {$random(seed)} % 5);
         pulse(c);
         apb(1'b0, 4 * IDX_WDT_CNT, 8'h00);
         r2 = r;
         apb(1'b0, 4 * IDX_WDT_CNT, 8'h00);
         chk({31'h0, r < 32'd16 && r > r2}, 32'h1);
         apb(1'b0, 4 * IDX_TB_CNT, 8'h00);
         chk({31'h0, r < 32'd16}, 32'h1);
         apb(1'b0, 4 * IDX_CAUSE, 8'h00);
         chk(r, {28'h0, 1'b1, 3'(c)});
         check_all();
      end
      apb(1'b0, 100, 8'h00);
      chk({e, r[30:0]}, 32'h8000_0000);
      apb(1'b1, 8'h05, 8'h00);
      chk({e, r[30:0]}, 32'h8000_0000);
      apb(1'b0, 8'h84, 8'h00);
      chk({e, r[30:0]}, 32'h8000_0000);
      report_and_stop();
   end
endmodule
`default_nettype wire
